/* rsx_defines.svh */
// rsx_defines.svh: constants of the rotate/set/skip execution slice
// assumes: included by the datapath modules rsx_alu and rsx_exec by bare name
`ifndef RSX_DEFINES_SVH
`define RSX_DEFINES_SVH

`define RSX_DATA_W 8
`define RSX_PC_W 11
`define RSX_MSB 7
`define RSX_LSB 0
`define RSX_ALL_ONES 8'hFF
`define RSX_ZERO 8'h00
`define RSX_ONE 8'h01
`define RSX_NIB_MSB 3
`define RSX_SKIP_CYCLES 2'h2
`define RSX_ONE_CYCLE 2'h1

`endif

/* rsx_pkg.sv */
// rsx_pkg.sv: operation codes of the execution slice
// assumes: the decode stage drives one of these codes with each issue strobe
package rsx_pkg;
	typedef enum logic [4:0] {
		RSX_OP_NOP,
		RSX_OP_SUB_EXIT,
		RSX_OP_SUB_EXIT_LIT,
		RSX_OP_IRQ_EXIT,
		RSX_OP_ROTATE_LEFT_MEM,
		RSX_OP_ROTATE_LEFT_TO_WORK,
		RSX_OP_ROTATE_LEFT_CARRY_MEM,
		RSX_OP_ROTATE_LEFT_CARRY_TO_WORK,
		RSX_OP_ROTATE_RIGHT_MEM,
		RSX_OP_ROTATE_RIGHT_TO_WORK,
		RSX_OP_ROTATE_RIGHT_CARRY_MEM,
		RSX_OP_ROTATE_RIGHT_CARRY_TO_WORK,
		RSX_OP_SUB_BORROW_TO_WORK,
		RSX_OP_SUB_BORROW_TO_MEM,
		RSX_OP_DEC_SKIP_ZERO_MEM,
		RSX_OP_DEC_SKIP_ZERO_WORK,
		RSX_OP_FILL_BYTE,
		RSX_OP_FILL_BIT,
		RSX_OP_INC_SKIP_ZERO_MEM,
		RSX_OP_INC_SKIP_ZERO_WORK,
		RSX_OP_BIT_SKIP_NONZERO
	} rsx_op_t;

	typedef enum logic [0:0] {
		RSX_ST_RUN,
		RSX_ST_DUMMY
	} rsx_state_t;
endpackage

/* rsx_alu.sv */
// rsx_alu.sv: combinational result and flag generator for the slice
// assumes: operands are stable registered values from the same clock
`timescale 1ns/10ps
`include "rsx_defines.svh"

module rsx_alu (
	// operation and operands
	input wire rsx_pkg::rsx_op_t i_op,
	input wire logic [`RSX_DATA_W-1:0] i_mem,
	input wire logic [`RSX_DATA_W-1:0] i_work,
	input wire logic [`RSX_DATA_W-1:0] i_lit,
	input wire logic [2:0] i_bit_sel,
	input wire logic i_carry,
	// results
	output logic [`RSX_DATA_W-1:0] o_result,
	output logic o_carry,
	output logic o_half,
	output logic o_wrap,
	output logic o_zero,
	output logic o_bit_set
);
	logic [`RSX_DATA_W-1:0] bit_mask;
	logic [`RSX_DATA_W:0] sbc_sum;
	logic [`RSX_NIB_MSB+1:0] sbc_low;
	logic [`RSX_DATA_W-1:0] inv_mem;

	assign bit_mask = `RSX_ONE << i_bit_sel;
	assign inv_mem = ~i_mem;
	// subtract as add of the inverted operand, carry acting as not-borrow
	assign sbc_sum = {1'b0, i_work} + {1'b0, inv_mem} + {8'h00, i_carry}; // RL17
	assign sbc_low = {1'b0, i_work[`RSX_NIB_MSB:0]} + {1'b0, inv_mem[`RSX_NIB_MSB:0]}
		+ {4'h0, i_carry};
	assign o_zero = (o_result == `RSX_ZERO);
	assign o_bit_set = |(i_mem & bit_mask); // RL11
	assign o_half = sbc_low[`RSX_NIB_MSB+1];
	assign o_wrap = (i_work[`RSX_MSB] == inv_mem[`RSX_MSB])
		&& (sbc_sum[`RSX_MSB] != i_work[`RSX_MSB]);

	always_comb begin
		o_result = i_mem;
		o_carry = i_carry;
		unique case (i_op)
			rsx_pkg::RSX_OP_SUB_EXIT_LIT: o_result = i_lit;
			rsx_pkg::RSX_OP_ROTATE_LEFT_MEM,
			rsx_pkg::RSX_OP_ROTATE_LEFT_TO_WORK: begin
				o_result = {i_mem[`RSX_MSB-1:0], i_mem[`RSX_MSB]};
			end
			rsx_pkg::RSX_OP_ROTATE_LEFT_CARRY_MEM,
			rsx_pkg::RSX_OP_ROTATE_LEFT_CARRY_TO_WORK: begin
				o_result = {i_mem[`RSX_MSB-1:0], i_carry}; // RL1 RL3
				o_carry = i_mem[`RSX_MSB]; // RL1 RL3
			end
			rsx_pkg::RSX_OP_ROTATE_RIGHT_MEM,
			rsx_pkg::RSX_OP_ROTATE_RIGHT_TO_WORK: begin
				o_result = {i_mem[`RSX_LSB], i_mem[`RSX_MSB:1]}; // RL4 RL5
			end
			rsx_pkg::RSX_OP_ROTATE_RIGHT_CARRY_MEM,
			rsx_pkg::RSX_OP_ROTATE_RIGHT_CARRY_TO_WORK: begin
				o_result = {i_carry, i_mem[`RSX_MSB:1]}; // RL6
				o_carry = i_mem[`RSX_LSB]; // RL6
			end
			rsx_pkg::RSX_OP_SUB_BORROW_TO_WORK,
			rsx_pkg::RSX_OP_SUB_BORROW_TO_MEM: begin
				o_result = sbc_sum[`RSX_DATA_W-1:0];
				o_carry = sbc_sum[`RSX_DATA_W];
			end
			rsx_pkg::RSX_OP_DEC_SKIP_ZERO_MEM,
			rsx_pkg::RSX_OP_DEC_SKIP_ZERO_WORK: o_result = i_mem - `RSX_ONE; // RL16
			rsx_pkg::RSX_OP_FILL_BYTE: o_result = `RSX_ALL_ONES; // RL7
			rsx_pkg::RSX_OP_FILL_BIT: o_result = i_mem | bit_mask; // RL8
			rsx_pkg::RSX_OP_INC_SKIP_ZERO_MEM,
			rsx_pkg::RSX_OP_INC_SKIP_ZERO_WORK: o_result = i_mem + `RSX_ONE; // RL9 RL10
			default: o_result = i_mem;
		endcase
	end
endmodule

/* rsx_exec.sv */
// rsx_exec.sv: execution slice for returns, rotates, fills, borrow subtract, skips
// assumes: decode issues one instruction per cycle with memory operand already read
`timescale 1ns/10ps
`include "rsx_defines.svh"

// How it works
// RL1: rotate-left-carry: bits up, carry in, bit7 out
// RL2: left-carry to work leaves memory unchanged
// RL3: work variant still updates carry both ways
// RL4: plain rotate right wraps bit0 to bit7
// RL5: right to work writes accumulator, memory kept
// RL6: rotate-right-carry: bit0 out, carry to bit7
// RL7: byte fill writes FFH, flags untouched
// RL8: bit fill forces only selected bit
// RL9: increment memory, skip when result zero
// RL10: increment to work, memory kept, skip zero
// RL11: bit test skips when selected bit set
// RL12: skip discards prefetched next instruction
// RL13: skipping instruction takes two cycles, dummy inserted
// RL14: no skip and no return: single cycle, continue normally
// RL15: returns reload pc; literal loads acc; irq enables
// RL16: decrement skip like increment skip
// RL17: borrow subtract updates four flags, either destination
module rsx_exec #(
	parameter int DATA_W = `RSX_DATA_W,
	parameter int PC_W = `RSX_PC_W
) (
	// clock, reset, enable
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_clk_en,
	// issue from decode
	input wire logic i_issue,
	input wire rsx_pkg::rsx_op_t i_op,
	input wire logic [DATA_W-1:0] i_mem_data,
	input wire logic [DATA_W-1:0] i_literal,
	input wire logic [2:0] i_bit_sel,
	input wire logic [PC_W-1:0] i_stack_top,
	// issue acceptance
	output logic o_ready,
	// memory write-back
	output logic o_mem_we,
	output logic [DATA_W-1:0] o_mem_wdata,
	// accumulator and flags
	output logic [DATA_W-1:0] o_work,
	output logic o_carry,
	output logic o_half_carry_flag,
	output logic o_signed_wrap_flag,
	output logic o_zero,
	output logic o_global_irq_enable,
	// flow control to fetch
	output logic o_pc_load,
	output logic [PC_W-1:0] o_pc_value,
	output logic o_stack_pop,
	output logic o_flush,
	output logic o_busy
);
	rsx_pkg::rsx_state_t state_ff, nxt_state;
	logic [DATA_W-1:0] work_ff, mem_wdata_ff, alu_result;
	logic carry_ff, half_ff, wrap_ff, zero_ff, gie_ff;
	logic mem_we_ff, pc_load_ff, pop_ff, flush_ff;
	logic [PC_W-1:0] pc_ff;
	logic alu_carry, alu_half, alu_wrap, alu_zero, alu_bit;

	rsx_alu u_alu (
		.i_op(i_op),
		.i_mem(i_mem_data),
		.i_work(work_ff),
		.i_lit(i_literal),
		.i_bit_sel(i_bit_sel),
		.i_carry(carry_ff),
		.o_result(alu_result),
		.o_carry(alu_carry),
		.o_half(alu_half),
		.o_wrap(alu_wrap),
		.o_zero(alu_zero),
		.o_bit_set(alu_bit)
	);

	// ----------------------------------------
	// decode of destination and effects
	// ----------------------------------------
	wire go = i_issue && i_clk_en && (state_ff == rsx_pkg::RSX_ST_RUN);
	wire is_ret = (i_op == rsx_pkg::RSX_OP_SUB_EXIT) || (i_op == rsx_pkg::RSX_OP_SUB_EXIT_LIT)
		|| (i_op == rsx_pkg::RSX_OP_IRQ_EXIT);
	wire is_sbc = (i_op == rsx_pkg::RSX_OP_SUB_BORROW_TO_WORK)
		|| (i_op == rsx_pkg::RSX_OP_SUB_BORROW_TO_MEM);
	wire is_inc_dec = (i_op == rsx_pkg::RSX_OP_INC_SKIP_ZERO_MEM)
		|| (i_op == rsx_pkg::RSX_OP_INC_SKIP_ZERO_WORK)
		|| (i_op == rsx_pkg::RSX_OP_DEC_SKIP_ZERO_MEM)
		|| (i_op == rsx_pkg::RSX_OP_DEC_SKIP_ZERO_WORK);
	wire carry_op = is_sbc
		|| (i_op == rsx_pkg::RSX_OP_ROTATE_LEFT_CARRY_MEM)
		|| (i_op == rsx_pkg::RSX_OP_ROTATE_LEFT_CARRY_TO_WORK)
		|| (i_op == rsx_pkg::RSX_OP_ROTATE_RIGHT_CARRY_MEM)
		|| (i_op == rsx_pkg::RSX_OP_ROTATE_RIGHT_CARRY_TO_WORK); // RL3
	// memory stays untouched by every to-work form
	wire to_work = (i_op == rsx_pkg::RSX_OP_SUB_EXIT_LIT)
		|| (i_op == rsx_pkg::RSX_OP_ROTATE_LEFT_TO_WORK)
		|| (i_op == rsx_pkg::RSX_OP_ROTATE_LEFT_CARRY_TO_WORK)
		|| (i_op == rsx_pkg::RSX_OP_ROTATE_RIGHT_TO_WORK)
		|| (i_op == rsx_pkg::RSX_OP_ROTATE_RIGHT_CARRY_TO_WORK)
		|| (i_op == rsx_pkg::RSX_OP_SUB_BORROW_TO_WORK)
		|| (i_op == rsx_pkg::RSX_OP_INC_SKIP_ZERO_WORK)
		|| (i_op == rsx_pkg::RSX_OP_DEC_SKIP_ZERO_WORK); // RL2 RL5 RL10
	wire to_mem = !to_work && !is_ret && (i_op != rsx_pkg::RSX_OP_NOP)
		&& (i_op != rsx_pkg::RSX_OP_BIT_SKIP_NONZERO); // RL7 RL8 RL9
	wire skip = (is_inc_dec && alu_zero)
		|| ((i_op == rsx_pkg::RSX_OP_BIT_SKIP_NONZERO) && alu_bit); // RL9 RL11 RL16
	// a return also refetches, so it costs the same dummy cycle
	wire two_cycle = skip || is_ret; // RL13 RL14

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			rsx_pkg::RSX_ST_RUN: if (go && two_cycle) nxt_state = rsx_pkg::RSX_ST_DUMMY;
			rsx_pkg::RSX_ST_DUMMY: if (i_clk_en) nxt_state = rsx_pkg::RSX_ST_RUN; // RL13
		endcase
	end

	// ----------------------------------------
	// state and architectural registers
	// ----------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_ff <= rsx_pkg::RSX_ST_RUN;
			work_ff <= `RSX_ZERO;
			{carry_ff, half_ff, wrap_ff, zero_ff, gie_ff} <= 5'h00;
		end else if (i_clk_en) begin
			state_ff <= nxt_state;
			if (go && to_work) work_ff <= alu_result; // RL15
			if (go && carry_op) carry_ff <= alu_carry; // RL1 RL6
			if (go && is_sbc) begin
				half_ff <= alu_half; // RL17
				wrap_ff <= alu_wrap;
				zero_ff <= alu_zero;
			end
			if (go && (i_op == rsx_pkg::RSX_OP_IRQ_EXIT)) gie_ff <= 1'b1; // RL15
		end
	end

	// one-cycle pulses toward memory and fetch
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			{mem_we_ff, pc_load_ff, pop_ff, flush_ff} <= 4'h0;
			mem_wdata_ff <= `RSX_ZERO;
			pc_ff <= '0;
		end else if (i_clk_en) begin
			mem_we_ff <= go && to_mem;
			if (go && to_mem) mem_wdata_ff <= alu_result;
			pc_load_ff <= go && is_ret;
			pop_ff <= go && is_ret;
			if (go && is_ret) pc_ff <= i_stack_top; // RL15
			flush_ff <= go && two_cycle; // RL12
		end
	end

	assign o_ready = (state_ff == rsx_pkg::RSX_ST_RUN);
	assign o_busy = (state_ff == rsx_pkg::RSX_ST_DUMMY);
	assign o_mem_we = mem_we_ff;
	assign o_mem_wdata = mem_wdata_ff;
	assign o_work = work_ff;
	assign o_carry = carry_ff;
	assign o_half_carry_flag = half_ff;
	assign o_signed_wrap_flag = wrap_ff;
	assign o_zero = zero_ff;
	assign o_global_irq_enable = gie_ff;
	assign o_pc_load = pc_load_ff;
	assign o_pc_value = pc_ff;
	assign o_stack_pop = pop_ff;
	assign o_flush = flush_ff;
endmodule

/* rsx_exec_checker.sv */
// rsx_exec_checker.sv: result and timing assertions for the execution slice
// assumes: bound onto rsx_exec by the bench, sees only its ports
`timescale 1ns/10ps
module rsx_exec_checker (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_clk_en,
	input wire logic i_issue,
	input wire rsx_pkg::rsx_op_t i_op,
	input wire logic [7:0] i_mem_data,
	input wire logic [2:0] i_bit_sel,
	input wire logic o_ready,
	input wire logic o_mem_we,
	input wire logic [7:0] o_mem_wdata,
	input wire logic [7:0] o_work,
	input wire logic o_carry,
	input wire logic o_global_irq_enable,
	input wire logic o_pc_load,
	input wire logic o_stack_pop,
	input wire logic o_flush,
	input wire logic o_busy
);
	// operands kept one cycle so results can be tied to their cause
	logic [7:0] mem_ff;
	logic [2:0] sel_ff;
	wire logic acc = i_issue && i_clk_en && o_ready;
	wire logic a_inc = acc && i_op == rsx_pkg::RSX_OP_INC_SKIP_ZERO_MEM;
	wire logic a_rr = acc && i_op == rsx_pkg::RSX_OP_ROTATE_RIGHT_MEM;
	wire logic a_rlw = acc && i_op == rsx_pkg::RSX_OP_ROTATE_LEFT_CARRY_TO_WORK;
	wire logic a_rrc = acc && i_op == rsx_pkg::RSX_OP_ROTATE_RIGHT_CARRY_MEM;
	wire logic a_fb = acc && i_op == rsx_pkg::RSX_OP_FILL_BYTE;
	wire logic a_fbit = acc && i_op == rsx_pkg::RSX_OP_FILL_BIT;
	wire logic a_bt = acc && i_op == rsx_pkg::RSX_OP_BIT_SKIP_NONZERO;
	wire logic a_irq = acc && i_op == rsx_pkg::RSX_OP_IRQ_EXIT;
	always_ff @(posedge i_sys_clk) begin
		mem_ff <= i_mem_data;
		sel_ff <= i_bit_sel;
	end
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);
	chk_inc_wrap_skip: assert property (a_inc && i_mem_data == 8'hFF |=> o_flush && o_mem_we && o_mem_wdata == 8'h00) else $error("inc wrap no skip");
	chk_inc_no_skip: assert property (a_inc && i_mem_data != 8'hFF |=> !o_flush && o_mem_wdata == mem_ff + 8'h01) else $error("inc skip wrong");
	chk_dummy_gap: assert property (o_flush |-> o_busy && !o_ready ##1 o_ready) else $error("dummy cycle wrong");
	chk_fill_ones: assert property (a_fb |=> o_mem_we && o_mem_wdata == 8'hFF && $stable(o_carry)) else $error("byte fill wrong");
	chk_fill_one_bit: assert property (a_fbit |=> o_mem_wdata == (mem_ff | (8'h01 << sel_ff))) else $error("bit fill wrong");
	chk_rr_wrap: assert property (a_rr |=> o_mem_wdata == {mem_ff[0], mem_ff[7:1]}) else $error("rotate right wrong");
	chk_rlc_work: assert property (a_rlw |=> !o_mem_we && o_carry == mem_ff[7] && o_work == {mem_ff[6:0], $past(o_carry)}) else $error("rlc work wrong");
	chk_rrc_mem: assert property (a_rrc |=> o_carry == mem_ff[0] && o_mem_wdata == {$past(o_carry), mem_ff[7:1]}) else $error("rrc wrong");
	chk_bit_test: assert property (a_bt |=> o_flush == mem_ff[sel_ff]) else $error("bit test wrong");
	chk_irq_exit: assert property (a_irq |=> o_pc_load && o_stack_pop && o_global_irq_enable) else $error("irq exit wrong");
	cover property (a_inc && i_mem_data == 8'hFF);
	cover property (i_issue && o_busy);
	cover property (a_irq);
endmodule

/* tb_rsx_exec.sv */
// tb_rsx_exec.sv: self-checking bench for the execution slice
// assumes: design and checker compiled first; 50 MHz clock
`timescale 1ns/10ps
module tb_rsx_exec;
	logic i_sys_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic i_clk_en = 1'b1;
	logic i_issue = 1'b0;
	rsx_pkg::rsx_op_t i_op = rsx_pkg::RSX_OP_NOP;
	logic [7:0] i_mem_data = 8'h00;
	logic [7:0] i_literal = 8'h10;
	logic [2:0] i_bit_sel = 3'h0;
	logic [10:0] i_stack_top = 11'h5A3;
	logic o_ready, o_mem_we, o_carry, o_half_carry_flag, o_signed_wrap_flag, o_zero;
	logic o_global_irq_enable, o_pc_load, o_stack_pop, o_flush, o_busy;
	logic [7:0] o_mem_wdata, o_work;
	logic [10:0] o_pc_value;
	int n_errors = 0;
	int compares = 0;
	always #10 i_sys_clk = ~i_sys_clk;
	rsx_exec u_dut (.*);
	task automatic cmp(input string nm, input logic [11:0] seen, input logic [11:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one issue, released after the taking edge; results are settled then
	task automatic go(input rsx_pkg::rsx_op_t op, input logic [7:0] m, input logic [2:0] s);
		@(posedge i_sys_clk);
		#1;
		i_op = op;
		i_mem_data = m;
		i_bit_sel = s;
		i_issue = 1'b1;
		@(posedge i_sys_clk);
		#1;
		i_issue = 1'b0;
	endtask
	// fields packed as {we, carry, data}
	task automatic t_rot();
		go(rsx_pkg::RSX_OP_ROTATE_LEFT_CARRY_MEM, 8'h81, 3'h0);
		cmp("rlc", {o_mem_we, o_carry, o_mem_wdata}, 12'h302);
		go(rsx_pkg::RSX_OP_ROTATE_LEFT_CARRY_TO_WORK, 8'h40, 3'h0);
		cmp("rotate_left_carry_to_work", {o_mem_we, o_carry, o_work}, 12'h081);
		go(rsx_pkg::RSX_OP_ROTATE_RIGHT_MEM, 8'h01, 3'h0);
		cmp("rr", {o_mem_we, o_carry, o_mem_wdata}, 12'h280);
		go(rsx_pkg::RSX_OP_ROTATE_RIGHT_TO_WORK, 8'h03, 3'h0);
		cmp("rra", {o_mem_we, o_carry, o_work}, 12'h081);
		go(rsx_pkg::RSX_OP_ROTATE_RIGHT_CARRY_MEM, 8'h01, 3'h0);
		cmp("rrc", {o_mem_we, o_carry, o_mem_wdata}, 12'h300);
		go(rsx_pkg::RSX_OP_ROTATE_RIGHT_CARRY_TO_WORK, 8'h02, 3'h0);
		cmp("rotate_right_carry_to_work", {o_mem_we, o_carry, o_work}, 12'h081);
		go(rsx_pkg::RSX_OP_ROTATE_LEFT_MEM, 8'h80, 3'h0);
		cmp("rl", o_mem_wdata, 12'h001);
		go(rsx_pkg::RSX_OP_ROTATE_LEFT_TO_WORK, 8'hC0, 3'h0);
		cmp("rla", o_work, 12'h081);
	endtask
	task automatic t_fill();
		go(rsx_pkg::RSX_OP_FILL_BYTE, 8'h00, 3'h0);
		cmp("fill", {o_mem_we, o_carry, o_mem_wdata}, 12'h2FF);
		for (int s = 0; s < 8; s++) begin
			go(rsx_pkg::RSX_OP_FILL_BIT, 8'h10, 3'(s));
			cmp("fbit", o_mem_wdata, 12'h010 | (12'h001 << s));
		end
	endtask
	// fields packed as {flush, busy, ready, we, data}
	task automatic t_skip();
		go(rsx_pkg::RSX_OP_INC_SKIP_ZERO_MEM, 8'hFF, 3'h0);
		cmp("siz", {o_flush, o_busy, o_ready, o_mem_we, o_mem_wdata}, 12'hD00);
		i_op = rsx_pkg::RSX_OP_FILL_BYTE;
		i_issue = 1'b1;
		@(posedge i_sys_clk);
		#1;
		i_issue = 1'b0;
		cmp("busy", {o_ready, o_mem_we}, 12'h2);
		go(rsx_pkg::RSX_OP_INC_SKIP_ZERO_MEM, 8'h7F, 3'h0);
		cmp("siz1", {o_flush, o_busy, o_ready, o_mem_we, o_mem_wdata}, 12'h380);
		go(rsx_pkg::RSX_OP_INC_SKIP_ZERO_WORK, 8'hFF, 3'h0);
		cmp("inc_skip_zero_work", {o_flush, o_mem_we, o_work}, 12'h200);
		go(rsx_pkg::RSX_OP_DEC_SKIP_ZERO_MEM, 8'h01, 3'h0);
		cmp("sdz", {o_flush, o_mem_we, o_mem_wdata}, 12'h300);
		go(rsx_pkg::RSX_OP_DEC_SKIP_ZERO_WORK, 8'h05, 3'h0);
		cmp("dec_skip_zero_work", {o_flush, o_mem_we, o_work}, 12'h004);
		go(rsx_pkg::RSX_OP_BIT_SKIP_NONZERO, 8'h08, 3'h3);
		cmp("snz", o_flush, 12'h1);
		go(rsx_pkg::RSX_OP_BIT_SKIP_NONZERO, 8'h08, 3'h2);
		cmp("snz0", o_flush, 12'h0);
	endtask
	task automatic t_ret_sbc();
		go(rsx_pkg::RSX_OP_SUB_EXIT, 8'h00, 3'h0);
		cmp("ret", {o_pc_load, o_stack_pop, o_pc_value[9:0]}, 12'hDA3);
		cmp("pc", o_pc_value, 12'h5A3);
		go(rsx_pkg::RSX_OP_ROTATE_LEFT_CARRY_MEM, 8'h80, 3'h0);
		go(rsx_pkg::RSX_OP_SUB_EXIT_LIT, 8'h00, 3'h0);
		cmp("retl", {o_pc_load, o_work}, 12'h110);
		go(rsx_pkg::RSX_OP_IRQ_EXIT, 8'h00, 3'h0);
		cmp("irq_exit", o_global_irq_enable, 12'h1);
		// {wrap, zero, half, carry, data}
		go(rsx_pkg::RSX_OP_SUB_BORROW_TO_WORK, 8'h01, 3'h0);
		cmp("sbc", {o_signed_wrap_flag, o_zero, o_half_carry_flag, o_carry, o_work}, 12'h10F);
		go(rsx_pkg::RSX_OP_SUB_BORROW_TO_MEM, 8'h0F, 3'h0);
		cmp("sub_borrow_to_mem", {o_signed_wrap_flag, o_zero, o_half_carry_flag, o_carry, o_mem_wdata}, 12'h700);
	endtask
	// enable low over an issue edge: nothing may be taken or change
	task automatic t_hold();
		@(posedge i_sys_clk);
		#1;
		i_clk_en = 1'b0;
		i_op = rsx_pkg::RSX_OP_FILL_BYTE;
		i_mem_data = 8'h00;
		i_issue = 1'b1;
		@(posedge i_sys_clk);
		#1;
		cmp("hold", {o_mem_we, o_mem_wdata}, 12'h000);
		i_issue = 1'b0;
		i_clk_en = 1'b1;
	endtask
	task automatic end_sim();
		if (n_errors == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		#20000;
		n_errors++;
		end_sim();
	end
	initial begin
		repeat (6) @(posedge i_sys_clk);
		#1;
		i_resetn = 1'b1;
		t_rot();
		t_fill();
		t_skip();
		t_ret_sbc();
		t_hold();
		end_sim();
	end
endmodule
bind rsx_exec rsx_exec_checker u_chk (.*);
